// ===== hw/dec_pkg.sv
package dec_pkg;

    // ==========================================================
    // Widths
    localparam int WORD_W = 16;
    localparam int CNT_W = 3;

    // ==========================================================
    // Upper-byte opcode patterns
    localparam logic [7:0] HI_ACC_SHORT = 8'hB9;
    localparam logic [7:0] HI_ACC_HIGH = 8'h6A;
    localparam logic [7:0] HI_ACC_LOW_UNS = 8'h69;
    localparam logic [7:0] HI_ACC_FACTOR = 8'h6B;
    localparam logic [7:0] HI_PAGE_DIR = 8'h0D;
    localparam logic [7:0] HI_STATUS_ZERO = 8'h0E;
    localparam logic [7:0] HI_STATUS_ONE = 8'h0F;
    localparam logic [7:0] HI_PROD_HIGH = 8'h75;
    localparam logic [7:0] HI_FACTOR = 8'h73;
    localparam logic [7:0] HI_FACTOR_ADD = 8'h70;
    localparam logic [7:0] HI_FACTOR_MOVE = 8'h72;
    localparam logic [7:0] HI_FACTOR_PROD = 8'h71;
    localparam logic [7:0] HI_FACTOR_SUB = 8'h74;
    localparam logic [7:0] HI_SUM_PROG = 8'hA2;
    localparam logic [7:0] HI_SUM_MOVE = 8'hA3;
    localparam logic [7:0] HI_AUX_MODIFY = 8'h8B;
    localparam logic [7:0] HI_PROD_FACTOR = 8'h54;
    localparam logic [7:0] HI_PROD_ADD = 8'h50;
    localparam logic [7:0] HI_PROD_SUB = 8'h51;
    localparam logic [7:0] HI_PROD_UNS = 8'h55;
    localparam logic [7:0] HI_NORMALIZE = 8'hA0;
    localparam logic [7:0] HI_OR_OPERAND = 8'h6D;

    // Partial-field patterns.
    localparam logic [4:0] TOP5_AUX_DIRECT = 5'h00;
    localparam logic [4:0] TOP5_AUX_SHORT = 5'h16;
    localparam logic [12:0] TOP13_AUX_LONG = 13'h17E1;
    localparam logic [6:0] TOP7_PAGE_IMM = 7'h5E;
    localparam logic [2:0] TOP3_PROD_CONST = 3'h6;
    localparam logic [11:0] TOP12_OR_SHIFT = 12'hBFC;
    localparam logic [4:0] LOW5_AUX_POINTER = 5'h11;
    localparam logic [7:0] LOW_IDLE = 8'h00;

    // Whole-word patterns and the shift-sixteen amount.
    localparam logic [15:0] W_TWOS_COMP = 16'hBE02;
    localparam logic [15:0] W_PROD_TO_ACC = 16'hBE03;
    localparam logic [15:0] W_NONMASKABLE = 16'hBE52;
    localparam logic [15:0] W_OR_SHIFT16 = 16'hBE82;
    localparam logic [4:0] SHIFT_SIXTEEN = 5'h10;

    // ==========================================================
    // Costs in words and cycles
    localparam logic [1:0] WORDS_ONE = 2'h1;
    localparam logic [1:0] WORDS_TWO = 2'h2;
    localparam logic [2:0] CYC_ONE = 3'h1;
    localparam logic [2:0] CYC_TWO = 3'h2;
    localparam logic [2:0] CYC_THREE = 3'h3;
    localparam logic [2:0] CYC_FOUR = 3'h4;

    // ==========================================================
    // Types
    typedef enum logic [5:0] {
        OP_OTHER, OP_ACC_LOAD_SHORT_CONST, OP_ACC_LOAD_HIGH_ZERO_LOW, OP_ACC_LOAD_LOW_UNSIGNED,
        OP_ACC_LOAD_FACTOR_SHIFTED, OP_AUX_REG_LOAD_DIRECT, OP_AUX_REG_LOAD_SHORT,
        OP_AUX_REG_LOAD_LONG, OP_PAGE_POINTER_LOAD, OP_PAGE_POINTER_LOAD_IMM,
        OP_PRODUCT_HIGH_LOAD, OP_STATUS_WORD_ZERO_LOAD, OP_STATUS_WORD_ONE_LOAD,
        OP_FACTOR_REG_LOAD, OP_FACTOR_LOAD_ADD_PRODUCT, OP_FACTOR_LOAD_ADD_MOVE,
        OP_FACTOR_LOAD_PRODUCT_TO_ACC, OP_FACTOR_LOAD_SUB_PRODUCT,
        OP_PRODUCT_SUM_PROGRAM_OPERAND, OP_PRODUCT_SUM_WITH_MOVE, OP_AUX_POINTER_LOAD,
        OP_AUX_REG_MODIFY, OP_IDLE_INSTRUCTION, OP_PRODUCT_WITH_FACTOR, OP_PRODUCT_WITH_CONST,
        OP_PRODUCT_THEN_ADD_PREV, OP_PRODUCT_THEN_SUB_PREV, OP_UNSIGNED_PRODUCT,
        OP_ACC_TWOS_COMPLEMENT, OP_NONMASKABLE_INT, OP_ACC_LEADING_BIT_SHIFT,
        OP_OR_OPERAND, OP_OR_IMM_SHIFT, OP_OR_IMM_SHIFT16, OP_PRODUCT_TO_ACC
    } op_t;

    typedef struct packed {
        op_t op;
        logic [2:0] aux_sel;
        logic direct;
        logic [6:0] dir_offset;
        logic [6:0] ind_code;
        logic [15:0] imm;
        logic [4:0] shift;
        logic [15:0] ext_word;
        logic [1:0] words;
        logic [2:0] cycles;
    } dec_t;

endpackage : dec_pkg

// ===== hw/operand_field_split.sv
`timescale 1ns/1ps

// Splits the low byte of a memory-reference word into mode and payload.
module operand_field_split (
    input wire logic [7:0] low_byte,
    output logic direct,
    output logic [6:0] dir_offset,
    output logic [6:0] ind_code
);
    // ==========================================================
    // Field split
    // Top bit clear selects a page offset, set selects an indirect update code.
    assign direct = ~low_byte[7];
    assign dir_offset = low_byte[7] ? 7'h00 : low_byte[6:0];
    assign ind_code = low_byte[7] ? low_byte[6:0] : 7'h00;

endmodule : operand_field_split

// ===== hw/stall_counter.sv
`timescale 1ns/1ps

// Holds the fetch side off for the extra cycles an instruction costs.
module stall_counter #(
    parameter int CNT_W = 3
) (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic load,
    input wire logic [CNT_W-1:0] count,
    output logic idle_q
);
    logic [CNT_W-1:0] cnt_q;
    logic [CNT_W-1:0] cnt_d;
    logic idle_d;

    // ==========================================================
    // Countdown
    // A load of zero leaves the counter idle, so single-cycle ops do not stall.
    assign cnt_d = load ? count : ((cnt_q != '0) ? cnt_q - 1'b1 : cnt_q);
    assign idle_d = load ? (count == '0) : (cnt_q <= {{(CNT_W-1){1'b0}}, 1'b1});

    // Counter and idle flag registers.
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q <= '0;
            idle_q <= 1'b1;
        end else begin
            cnt_q <= cnt_d;
            idle_q <= idle_d;
        end
    end

endmodule : stall_counter

// ===== hw/opcode_decoder.sv
`timescale 1ns/1ps

module opcode_decoder
    import dec_pkg::*;
#(
    parameter int WORD_W = 16
) (
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic [WORD_W-1:0] fetch_word,
    input wire logic fetch_valid,
    output logic fetch_ready,
    output dec_pkg::dec_t dec_q,
    output logic dec_valid_q
);
    import dec_pkg::*;

    typedef enum logic [0:0] {ST_IDLE, ST_SECOND} state_t;

    // ==========================================================
    // Reset release
    logic [1:0] rst_sync_q;
    logic rst_n;

    // Reset asserts at once and releases after two clock edges.
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            rst_sync_q <= 2'b00;
        end else begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_q[1];

    // ==========================================================
    // Handshake
    state_t state_q;
    state_t state_d;
    logic idle_q;
    logic accept;
    logic first_take;
    logic second_take;

    assign fetch_ready = idle_q;
    assign accept = fetch_valid & idle_q;
    assign first_take = accept & (state_q == ST_IDLE);
    assign second_take = accept & (state_q == ST_SECOND);

    // ==========================================================
    // Pattern match
    logic [7:0] hi;
    logic [7:0] lo;
    logic m_acc_short, m_acc_high, m_acc_low_uns, m_acc_factor;
    logic m_aux_dir, m_aux_short, m_aux_long, m_page_dir, m_page_imm;
    logic m_prod_high, m_status_zero, m_status_one;
    logic m_factor, m_factor_add, m_factor_move, m_factor_prod, m_factor_sub;
    logic m_sum_prog, m_sum_move, m_aux_modify, m_aux_pointer, m_idle;
    logic m_prod_factor, m_prod_const, m_prod_add, m_prod_sub, m_prod_uns;
    logic m_twos, m_prod_acc, m_nonmask, m_acc_leading_bit_shift, m_or_op, m_or_shift, m_or_sixteen;

    assign hi = fetch_word[15:8];
    assign lo = fetch_word[7:0];

    // Accumulator loads.
    assign m_acc_short = (hi == HI_ACC_SHORT);
    assign m_acc_high = (hi == HI_ACC_HIGH);
    assign m_acc_low_uns = (hi == HI_ACC_LOW_UNS);
    assign m_acc_factor = (hi == HI_ACC_FACTOR);

    // Auxiliary, page pointer, status and product-high loads.
    assign m_aux_dir = (fetch_word[15:11] == TOP5_AUX_DIRECT);
    assign m_aux_short = (fetch_word[15:11] == TOP5_AUX_SHORT);
    assign m_aux_long = (fetch_word[15:3] == TOP13_AUX_LONG);
    assign m_page_dir = (hi == HI_PAGE_DIR);
    assign m_page_imm = (fetch_word[15:9] == TOP7_PAGE_IMM);
    assign m_status_zero = (hi == HI_STATUS_ZERO);
    assign m_status_one = (hi == HI_STATUS_ONE);
    assign m_prod_high = (hi == HI_PROD_HIGH);

    // Factor register family.
    assign m_factor = (hi == HI_FACTOR);
    assign m_factor_add = (hi == HI_FACTOR_ADD);
    assign m_factor_move = (hi == HI_FACTOR_MOVE);
    assign m_factor_prod = (hi == HI_FACTOR_PROD);
    assign m_factor_sub = (hi == HI_FACTOR_SUB);

    // Multiply-accumulate and auxiliary modify.
    assign m_sum_prog = (hi == HI_SUM_PROG);
    assign m_sum_move = (hi == HI_SUM_MOVE);
    assign m_aux_modify = (hi == HI_AUX_MODIFY);
    assign m_aux_pointer = m_aux_modify & (lo[7:3] == LOW5_AUX_POINTER);
    assign m_idle = m_aux_modify & (lo == LOW_IDLE);

    // Multiplies.
    assign m_prod_factor = (hi == HI_PROD_FACTOR);
    assign m_prod_const = (fetch_word[15:13] == TOP3_PROD_CONST);
    assign m_prod_add = (hi == HI_PROD_ADD);
    assign m_prod_sub = (hi == HI_PROD_SUB);
    assign m_prod_uns = (hi == HI_PROD_UNS);

    // Accumulator operations, nonmaskable interrupt and OR forms.
    assign m_twos = (fetch_word == W_TWOS_COMP);
    assign m_prod_acc = (fetch_word == W_PROD_TO_ACC);
    assign m_nonmask = (fetch_word == W_NONMASKABLE);
    assign m_acc_leading_bit_shift = (hi == HI_NORMALIZE);
    assign m_or_op = (hi == HI_OR_OPERAND);
    assign m_or_shift = (fetch_word[15:4] == TOP12_OR_SHIFT);
    assign m_or_sixteen = (fetch_word == W_OR_SHIFT16);

    // ==========================================================
    // Operation select
    // Patterns overlap only where idle and pointer load sit inside plain modify, and they win over it.
    op_t op_w;
    assign op_w =
        m_acc_short ? OP_ACC_LOAD_SHORT_CONST :
        m_acc_high ? OP_ACC_LOAD_HIGH_ZERO_LOW :
        m_acc_low_uns ? OP_ACC_LOAD_LOW_UNSIGNED :
        m_acc_factor ? OP_ACC_LOAD_FACTOR_SHIFTED :
        m_aux_dir ? OP_AUX_REG_LOAD_DIRECT :
        m_aux_short ? OP_AUX_REG_LOAD_SHORT :
        m_aux_long ? OP_AUX_REG_LOAD_LONG :
        m_page_dir ? OP_PAGE_POINTER_LOAD :
        m_page_imm ? OP_PAGE_POINTER_LOAD_IMM :
        m_prod_high ? OP_PRODUCT_HIGH_LOAD :
        m_status_zero ? OP_STATUS_WORD_ZERO_LOAD :
        m_status_one ? OP_STATUS_WORD_ONE_LOAD :
        m_factor ? OP_FACTOR_REG_LOAD :
        m_factor_add ? OP_FACTOR_LOAD_ADD_PRODUCT :
        m_factor_move ? OP_FACTOR_LOAD_ADD_MOVE :
        m_factor_prod ? OP_FACTOR_LOAD_PRODUCT_TO_ACC :
        m_factor_sub ? OP_FACTOR_LOAD_SUB_PRODUCT :
        m_sum_prog ? OP_PRODUCT_SUM_PROGRAM_OPERAND :
        m_sum_move ? OP_PRODUCT_SUM_WITH_MOVE :
        m_idle ? OP_IDLE_INSTRUCTION :
        m_aux_pointer ? OP_AUX_POINTER_LOAD :
        m_aux_modify ? OP_AUX_REG_MODIFY :
        m_prod_factor ? OP_PRODUCT_WITH_FACTOR :
        m_prod_const ? OP_PRODUCT_WITH_CONST :
        m_prod_add ? OP_PRODUCT_THEN_ADD_PREV :
        m_prod_sub ? OP_PRODUCT_THEN_SUB_PREV :
        m_prod_uns ? OP_UNSIGNED_PRODUCT :
        m_twos ? OP_ACC_TWOS_COMPLEMENT :
        m_prod_acc ? OP_PRODUCT_TO_ACC :
        m_nonmask ? OP_NONMASKABLE_INT :
        m_acc_leading_bit_shift ? OP_ACC_LEADING_BIT_SHIFT :
        m_or_op ? OP_OR_OPERAND :
        m_or_shift ? OP_OR_IMM_SHIFT :
        m_or_sixteen ? OP_OR_IMM_SHIFT16 : OP_OTHER;

    // ==========================================================
    // Cost lookup
    logic two_word;
    logic [2:0] cyc_w;
    logic [1:0] words_w;

    // Two-word forms carry a constant or program address in the next word.
    assign two_word = m_aux_long | m_sum_prog | m_sum_move | m_or_shift | m_or_sixteen;
    assign words_w = two_word ? WORDS_TWO : WORDS_ONE;
    assign cyc_w =
        m_nonmask ? CYC_FOUR :
        (m_sum_prog | m_sum_move) ? CYC_THREE :
        (m_aux_dir | m_aux_short | m_aux_long | m_page_dir | m_page_imm |
         m_status_zero | m_status_one | m_or_shift | m_or_sixteen) ? CYC_TWO :
        CYC_ONE;

    // ==========================================================
    // Field extraction
    logic f_direct;
    logic [6:0] f_offset;
    logic [6:0] f_ind;
    logic [15:0] imm_w;
    logic [4:0] shift_w;
    logic has_aux_sel;
    dec_t dec_w;

    operand_field_split u_field (
        .low_byte(lo),
        .direct(f_direct),
        .dir_offset(f_offset),
        .ind_code(f_ind)
    );

    // Immediate payload, zero extended; a zero byte on short load clears.
    assign imm_w =
        (m_acc_short | m_aux_short) ? {8'h00, lo} :
        m_page_imm ? {7'h00, fetch_word[8:0]} :
        m_prod_const ? {3'h0, fetch_word[12:0]} : 16'h0000;
    assign shift_w = m_or_sixteen ? SHIFT_SIXTEEN :
        (m_or_shift ? {1'b0, fetch_word[3:0]} : 5'h00);
    assign has_aux_sel = m_aux_dir | m_aux_short | m_aux_long | m_aux_pointer;

    // Only memory-reference forms carry a mode byte.
    logic mem_ref;
    assign mem_ref = m_acc_high | m_acc_low_uns | m_acc_factor | m_aux_dir | m_page_dir |
        m_prod_high | m_status_zero | m_status_one | m_factor | m_factor_add |
        m_factor_move | m_factor_prod | m_factor_sub | m_sum_prog | m_sum_move |
        (m_aux_modify & ~m_aux_pointer & ~m_idle) | m_prod_factor | m_prod_add |
        m_prod_sub | m_prod_uns | m_acc_leading_bit_shift | m_or_op;

    always_comb begin
        dec_w = '0;
        dec_w.op = op_w;
        dec_w.aux_sel = has_aux_sel ?
            (m_aux_dir | m_aux_short ? fetch_word[10:8] : fetch_word[2:0]) : 3'h0;
        dec_w.direct = mem_ref & f_direct;
        dec_w.dir_offset = mem_ref ? f_offset : 7'h00;
        dec_w.ind_code = mem_ref ? f_ind : 7'h00;
        dec_w.imm = imm_w;
        dec_w.shift = shift_w;
        dec_w.words = words_w;
        dec_w.cycles = cyc_w;
    end

    // ==========================================================
    // Sequencing
    dec_t hold_q;
    dec_t dec_d;
    logic valid_d;
    logic stall_load;
    logic [2:0] stall_cnt;
    dec_t second_w;

    // The second word completes the held first word as its trailing constant.
    always_comb begin
        second_w = hold_q;
        second_w.ext_word = fetch_word;
    end

    assign state_d = (first_take & two_word) ? ST_SECOND :
        (second_take ? ST_IDLE : state_q);
    assign valid_d = (first_take & ~two_word) | second_take;
    assign dec_d = second_take ? second_w : (first_take ? dec_w : dec_q);
    // Extra stall is the cycle cost beyond the words already fetched.
    assign stall_load = valid_d;
    assign stall_cnt = dec_d.cycles - {1'b0, dec_d.words};

    // State, pending first word and output registers.
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= ST_IDLE;
            hold_q <= '0;
            dec_q <= '0;
            dec_valid_q <= 1'b0;
        end else begin
            state_q <= state_d;
            hold_q <= first_take ? dec_w : hold_q;
            dec_q <= dec_d;
            dec_valid_q <= valid_d;
        end
    end

    stall_counter #(.CNT_W(CNT_W)) u_stall (
        .mclk(mclk),
        .rst_n(rst_n),
        .load(stall_load),
        .count(stall_cnt),
        .idle_q(idle_q)
    );

    // ==========================================================
    // Checks
    a_short_const: assert property (@(posedge mclk) disable iff (!rst_n)
        first_take && m_acc_short |=> dec_valid_q && dec_q.op == OP_ACC_LOAD_SHORT_CONST
        && dec_q.imm == {8'h00, $past(fetch_word[7:0])} && dec_q.cycles == 3'd1)
        else $error("short constant load decoded wrongly");

    a_aux_select: assert property (@(posedge mclk) disable iff (!rst_n)
        first_take && m_aux_dir |=> dec_q.aux_sel == $past(fetch_word[10:8])
        && dec_q.op == OP_AUX_REG_LOAD_DIRECT)
        else $error("aux select field not passed through");

    a_aux_stall: assert property (@(posedge mclk) disable iff (!rst_n)
        dec_valid_q && dec_q.op == OP_AUX_REG_LOAD_SHORT |-> !fetch_ready ##1 fetch_ready)
        else $error("aux short load did not stall one cycle");

    a_long_aux_pair: assert property (@(posedge mclk) disable iff (!rst_n)
        first_take && m_aux_long |=> !dec_valid_q && state_q == ST_SECOND)
        else $error("long aux load emitted before second word");

    a_sum_cost: assert property (@(posedge mclk) disable iff (!rst_n)
        dec_valid_q && dec_q.op == OP_PRODUCT_SUM_WITH_MOVE |-> dec_q.words == 2'd2
        && dec_q.cycles == 3'd3 && !fetch_ready ##1 fetch_ready)
        else $error("multiply-accumulate cost wrong");

    a_nonmask_stall: assert property (@(posedge mclk) disable iff (!rst_n)
        dec_valid_q && dec_q.op == OP_NONMASKABLE_INT |-> !fetch_ready [*3] ##1 fetch_ready)
        else $error("nonmaskable interrupt did not cost four cycles");

    // The single stall cycle is the one in which the result appears.
    a_page_value: assert property (@(posedge mclk) disable iff (!rst_n)
        first_take && m_page_imm |=> dec_q.imm == {7'h00, $past(fetch_word[8:0])}
        && !fetch_ready ##1 fetch_ready)
        else $error("page immediate wrong");

    a_mode_bit: assert property (@(posedge mclk) disable iff (!rst_n)
        first_take && m_acc_high |=> dec_q.direct == !$past(fetch_word[7])
        && dec_q.dir_offset == ($past(fetch_word[7]) ? 7'h00 : $past(fetch_word[6:0])))
        else $error("mode split wrong");

    a_prod_const: assert property (@(posedge mclk) disable iff (!rst_n)
        first_take && m_prod_const |=> dec_q.op == OP_PRODUCT_WITH_CONST
        && dec_q.imm[12:0] == $past(fetch_word[12:0]) && fetch_ready)
        else $error("multiply constant decoded wrongly");

    a_or_sixteen: assert property (@(posedge mclk) disable iff (!rst_n)
        second_take && hold_q.op == OP_OR_IMM_SHIFT16 |=> dec_valid_q
        && dec_q.shift == 5'h10 && dec_q.ext_word == $past(fetch_word))
        else $error("shift-sixteen OR wrong");

    // Two words and two cycles leave no stall after the constant is taken.
    a_long_aux_cost: assert property (@(posedge mclk) disable iff (!rst_n)
        second_take && hold_q.op == OP_AUX_REG_LOAD_LONG |=> dec_valid_q
        && dec_q.words == 2'd2 && dec_q.cycles == 3'd2 && fetch_ready)
        else $error("long aux load cost wrong");

    a_or_shift_cost: assert property (@(posedge mclk) disable iff (!rst_n)
        second_take && hold_q.op == OP_OR_IMM_SHIFT |=> dec_valid_q && dec_q.words == 2'd2
        && dec_q.cycles == 3'd2 && dec_q.ext_word == $past(fetch_word) && fetch_ready)
        else $error("shifted OR immediate cost wrong");

    c_two_word: cover property (@(posedge mclk) disable iff (!rst_n)
        first_take && m_sum_prog ##[1:4] second_take);
    c_nonmask: cover property (@(posedge mclk) disable iff (!rst_n)
        dec_valid_q && dec_q.op == OP_NONMASKABLE_INT);
    c_back_to_back: cover property (@(posedge mclk) disable iff (!rst_n)
        dec_valid_q ##1 dec_valid_q);
    c_aux_pointer: cover property (@(posedge mclk) disable iff (!rst_n)
        dec_valid_q && dec_q.op == OP_AUX_POINTER_LOAD);
    c_long_aux: cover property (@(posedge mclk) disable iff (!rst_n)
        dec_valid_q && dec_q.op == OP_AUX_REG_LOAD_LONG);

endmodule : opcode_decoder

// ===== sim/prog_mem_model.sv
`timescale 1ns/1ps

// ==========================================================
// Program memory model
// Offers queued words in order and holds each one until it is taken.
module prog_mem_model (
    input wire logic mclk,
    input wire logic fetch_ready,
    input wire logic gap,
    output logic [15:0] fetch_word,
    output logic fetch_valid
);
    logic [15:0] pend[$];
    logic taken = 1'b0;

    // Queues one word for delivery.
    task automatic push(input logic [15:0] w);
        pend.push_back(w);
    endtask : push

    // Both outputs start quiet.
    initial begin
        fetch_word = 16'h0000;
        fetch_valid = 1'b0;
    end

    // Notes whether the offered word was taken at this edge.
    always @(posedge mclk) taken <= fetch_valid & fetch_ready;

    // Moves on after a take; an idle gap toggles the data so stale words never look valid.
    always @(negedge mclk) begin
        if (taken && pend.size() > 0) void'(pend.pop_front());
        if (pend.size() > 0 && ((fetch_valid && !taken) || !gap)) begin
            fetch_valid = 1'b1;
            fetch_word = pend[0];
        end else begin
            fetch_valid = 1'b0;
            fetch_word = ~fetch_word;
        end
    end
endmodule : prog_mem_model

// ===== sim/dsp_core_opcode_decode_load_mul_tb.sv
`timescale 1ns/1ps

// ==========================================================
// Decoder testbench
module dsp_core_opcode_decode_load_mul_tb;
    import dec_pkg::*;

    typedef struct {
        op_t op;
        logic [2:0] c;
        logic [2:0] aux;
        logic [1:0] kind;
        logic [15:0] v;
        logic [7:0] low;
    } note_t;

    localparam int NM = 18;
    logic [7:0] m_hi[NM] = '{8'h6A, 8'h69, 8'h6B, 8'h0D, 8'h0E, 8'h0F, 8'h73, 8'h70, 8'h72,
        8'h71, 8'h74, 8'h54, 8'h50, 8'h51, 8'h55, 8'hA0, 8'h6D, 8'h75};
    op_t m_op[NM] = '{OP_ACC_LOAD_HIGH_ZERO_LOW, OP_ACC_LOAD_LOW_UNSIGNED,
        OP_ACC_LOAD_FACTOR_SHIFTED, OP_PAGE_POINTER_LOAD, OP_STATUS_WORD_ZERO_LOAD,
        OP_STATUS_WORD_ONE_LOAD, OP_FACTOR_REG_LOAD, OP_FACTOR_LOAD_ADD_PRODUCT,
        OP_FACTOR_LOAD_ADD_MOVE, OP_FACTOR_LOAD_PRODUCT_TO_ACC, OP_FACTOR_LOAD_SUB_PRODUCT,
        OP_PRODUCT_WITH_FACTOR, OP_PRODUCT_THEN_ADD_PREV, OP_PRODUCT_THEN_SUB_PREV,
        OP_UNSIGNED_PRODUCT, OP_ACC_LEADING_BIT_SHIFT, OP_OR_OPERAND, OP_PRODUCT_HIGH_LOAD};
    logic mclk = 1'b0;
    logic rst_b = 1'b0;
    logic gap = 1'b0;
    logic [15:0] fetch_word;
    logic fetch_valid;
    logic fetch_ready;
    logic dec_valid_q;
    dec_t dec_q;
    note_t exp_q[$];
    int n_fail = 0;
    int tests_run = 0;
    logic [31:0] rs = 32'h4DBA61F6;

    always #2 mclk = ~mclk;

    opcode_decoder #(.WORD_W(16)) opcode_decoder_i (.mclk(mclk), .rst_b(rst_b),
        .fetch_word(fetch_word), .fetch_valid(fetch_valid), .fetch_ready(fetch_ready),
        .dec_q(dec_q), .dec_valid_q(dec_valid_q));
    prog_mem_model prog_mem_model_i (.mclk(mclk), .fetch_ready(fetch_ready), .gap(gap),
        .fetch_word(fetch_word), .fetch_valid(fetch_valid));

    // Steps the xorshift generator.
    function automatic logic [31:0] rnd();
        rs ^= rs << 13;
        rs ^= rs >> 17;
        rs ^= rs << 5;
        return rs;
    endfunction : rnd

    // Counts one comparison and reports a mismatch.
    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_fail++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    // Notes the expected decode and hands the words to memory; kind 2 means two words.
    task automatic send(input logic [15:0] w0, input logic [15:0] w1, input op_t op,
            input logic [2:0] c, input logic [2:0] aux, input logic [1:0] kind,
            input logic [15:0] v);
        exp_q.push_back('{op, c, aux, kind, v, w0[7:0]});
        prog_mem_model_i.push(w0);
        if (kind == 2'h2) prog_mem_model_i.push(w1);
    endtask : send

    // Prints the counts and the verdict, then stops.
    task automatic complete_run();
        $display("Counts: tests_run %0d n_fail %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : complete_run

    // Memory pauses now and then to stretch the handshakes.
    always @(negedge mclk) begin
        logic [31:0] t;
        t = rnd();
        gap <= &t[1:0];
    end

    // Compares each result with the oldest note, then measures the fetch stall.
    initial begin
        note_t n;
        int st;
        logic [15:0] sh;
        forever begin
            @(negedge mclk);
            if (dec_valid_q === 1'b1) begin
                n = exp_q.pop_front();
                check("op", 16'(dec_q.op), 16'(n.op));
                check("words", 16'(dec_q.words), (n.kind == 2'h2) ? 16'h0002 : 16'h0001);
                check("cycles", 16'(dec_q.cycles), 16'(n.c));
                check("aux_sel", 16'(dec_q.aux_sel), 16'(n.aux));
                if (n.kind == 2'h1) check("imm", dec_q.imm, n.v);
                if (n.kind == 2'h2) check("ext_word", dec_q.ext_word, n.v);
                // Only the OR immediate forms carry a shift amount.
                sh = (n.op == OP_OR_IMM_SHIFT16) ? 16'h0010 : 16'h0000;
                if (n.op == OP_OR_IMM_SHIFT) sh = 16'(n.low[3:0]);
                check("shift", 16'(dec_q.shift), sh);
                if (n.kind == 2'h3) check("mode", 16'({dec_q.direct, dec_q.dir_offset,
                    dec_q.ind_code}), 16'({~n.low[7], n.low[7] ? 7'h00 : n.low[6:0],
                    n.low[7] ? n.low[6:0] : 7'h00}));
                st = 0;
                while (fetch_ready === 1'b0 && st < 8) begin
                    st++;
                    @(negedge mclk);
                end
                check("stall", 16'(st),
                    16'(n.c) - ((n.kind == 2'h2) ? 16'h0002 : 16'h0001));
            end
        end
    end

    // Cuts a hang short.
    initial begin
        #20000;
        n_fail++;
        $display("Error watchdog expected done seen timeout");
        complete_run();
    end

    // Main sequence.
    initial begin
        logic [31:0] r;
        logic [2:0] a;
        repeat (10) @(negedge mclk);
        rst_b = 1'b1;
        repeat (3) @(negedge mclk);
        for (int i = 0; i < NM; i++) begin
            r = rnd();
            send({m_hi[i], r[7:0]}, 16'h0000, m_op[i], (m_hi[i][7:4] == 4'h0) ? 3'h2 : 3'h1,
                3'h0, 2'h3, 16'h0000);
        end
        send(16'hB900, 16'h0000, OP_ACC_LOAD_SHORT_CONST, 3'h1, 3'h0, 2'h1, 16'h0000);
        send(16'h8B00, 16'h0000, OP_IDLE_INSTRUCTION, 3'h1, 3'h0, 2'h0, 16'h0000);
        send(16'h8B21, 16'h0000, OP_AUX_REG_MODIFY, 3'h1, 3'h0, 2'h3, 16'h0000);
        send(16'h8BA5, 16'h0000, OP_AUX_REG_MODIFY, 3'h1, 3'h0, 2'h3, 16'h0000);
        send(16'hBE03, 16'h0000, OP_PRODUCT_TO_ACC, 3'h1, 3'h0, 2'h0, 16'h0000);
        send(16'hBE02, 16'h0000, OP_ACC_TWOS_COMPLEMENT, 3'h1, 3'h0, 2'h0, 16'h0000);
        send(16'hBE52, 16'h0000, OP_NONMASKABLE_INT, 3'h4, 3'h0, 2'h0, 16'h0000);
        send(16'hBE82, 16'hC35A, OP_OR_IMM_SHIFT16, 3'h2, 3'h0, 2'h2, 16'hC35A);
        send(16'hBE00, 16'h0000, OP_OTHER, 3'h1, 3'h0, 2'h0, 16'h0000);
        $display("test fixed words done");
        for (int k = 0; k < 8; k++) begin
            r = rnd();
            a = 3'(k);
            send({5'h00, a, r[7:0]}, 16'h0000, OP_AUX_REG_LOAD_DIRECT, 3'h2, a, 2'h3,
                16'h0000);
            send({5'h16, a, r[15:8]}, 16'h0000, OP_AUX_REG_LOAD_SHORT, 3'h2, a, 2'h1,
                {8'h00, r[15:8]});
            send({13'h17E1, a}, r[31:16], OP_AUX_REG_LOAD_LONG, 3'h2, a, 2'h2, r[31:16]);
            send({13'h1171, a}, 16'h0000, OP_AUX_POINTER_LOAD, 3'h1, a, 2'h0, 16'h0000);
            send({7'h5E, r[8:0]}, 16'h0000, OP_PAGE_POINTER_LOAD_IMM, 3'h2, 3'h0, 2'h1,
                {7'h00, r[8:0]});
            send({3'h6, r[28:16]}, 16'h0000, OP_PRODUCT_WITH_CONST, 3'h1, 3'h0, 2'h1,
                {3'h0, r[28:16]});
            send({8'hB9, r[7:0]}, 16'h0000, OP_ACC_LOAD_SHORT_CONST, 3'h1, 3'h0, 2'h1,
                {8'h00, r[7:0]});
            send({7'h51, a[0], r[7:0]}, r[31:16], a[0] ? OP_PRODUCT_SUM_WITH_MOVE :
                OP_PRODUCT_SUM_PROGRAM_OPERAND, 3'h3, 3'h0, 2'h2, r[31:16]);
            send({12'hBFC, r[3:0]}, r[31:16], OP_OR_IMM_SHIFT, 3'h2, 3'h0, 2'h2, r[31:16]);
        end
        for (int t = 0; t < 3000 && exp_q.size() > 0; t++) @(negedge mclk);
        repeat (4) @(negedge mclk);
        check("pending", 16'(exp_q.size()), 16'h0000);
        $display("test random fields done");
        complete_run();
    end
endmodule : dsp_core_opcode_decode_load_mul_tb
